// ### pkg/sbl_pkg.sv
// Purpose : constants and types of the serial link self-test block
// Assumes : AXI4-Lite register access, 32-bit data
// Notes   : one shared definition of offsets, fields and reset values
`default_nettype none
package sbl_pkg;
  // ----------------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------------
  localparam int PIX_W = 24;
  localparam int CNT_W = 8;
  localparam int ADDR_W = 8;
  // ----------------------------------------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_BIST_CRC = 8'h08;
  localparam logic [7:0] OFS_FUNC_CRC = 8'h0C;
  localparam logic [7:0] OFS_CLEAR = 8'h10;
  // ----------------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------------
  localparam int CTRL_LF_BIT = 0;
  localparam int CTRL_USE_REG_BIT = 1;
  localparam int CTRL_OSC25_BIT = 2;
  localparam int CLR_BIST_BIT = 0;
  localparam int CLR_FUNC_BIT = 1;
  localparam int ST_ACTIVE_BIT = 0;
  localparam int ST_LINK_BIT = 1;
  localparam int ST_PCLK_BIT = 2;
  localparam int ST_BC_BIT = 3;
  localparam int ST_SRC_LSB = 4;
  localparam int ST_KHZ_LSB = 16;
  // ----------------------------------------------------------------------
  // reset values and responses
  // ----------------------------------------------------------------------
  localparam logic CTRL_LF_RST = 1'b0;
  localparam logic CTRL_USE_REG_RST = 1'b0;
  localparam logic CTRL_OSC25_RST = 1'b0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ----------------------------------------------------------------------
  // oscillator frequencies in kHz
  // ----------------------------------------------------------------------
  localparam logic [15:0] OSC_33_KHZ = 16'h80E8;   // 33000
  localparam logic [15:0] OSC_25_KHZ = 16'h61A8;   // 25000
  localparam logic [15:0] OSC_12P5_KHZ = 16'h30D4; // 12500
  // ----------------------------------------------------------------------
  // types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    SRC_PIXEL = 2'b00,
    SRC_OSC_33 = 2'b01,
    SRC_OSC_25 = 2'b10,
    SRC_OSC_12P5 = 2'b11
  } sbl_src_type;

  typedef struct packed {
    logic low_freq;
    logic backward_compat;
  } sbl_strap_type;

  typedef struct packed {
    logic [CNT_W-1:0] count;
  } sbl_cnt_type;
endpackage
`default_nettype wire

// ### src/sbl_err_counter.sv
// Purpose : saturating error counter with clear and count enable
// Assumes : inc and clr come from logic on the same clock
// Notes   : a count arriving with a clear is kept, the result is one
`timescale 1ns/1ps
`default_nettype none
module sbl_err_counter
  import sbl_pkg::*;
(
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic             en,
  input  wire logic             inc,
  input  wire logic             clr,
  output logic      [CNT_W-1:0] count
);
  sbl_cnt_type st_reg;
  sbl_cnt_type st_next;
  logic        hit;

  // ----------------------------------------------------------------------
  // next count
  // ----------------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    hit = en & inc;
    if (clr) begin
      st_next.count = hit ? CNT_W'(1) : '0;
    end else if (hit && (st_reg.count != '1)) begin
      st_next.count = st_reg.count + CNT_W'(1);
    end
  end

  // state register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign count = st_reg.count;
endmodule
`default_nettype wire

// ### src/sbl_selftest.sv
// Purpose : serializer side of the at-speed serial link self-test
// Assumes : back-channel request, link detect and crc error come
//           from logic on aclk; strap and clock-present pins do not
// Notes   : mode changes take effect at frame_start only
//
// Added by the designer: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module sbl_selftest
  import sbl_pkg::*;
(
  input  wire logic                aclk,
  input  wire logic                aresetn,
  // axi4-lite slave
  input  wire logic [ADDR_W-1:0]   s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  input  wire logic [ADDR_W-1:0]   s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  output logic [31:0]              s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready,
  // link side
  input  wire logic                bc_selftest_req,
  input  wire logic                bc_link_detect,
  input  wire logic                bc_crc_error,
  input  wire logic                frame_start,
  input  wire logic [PIX_W-1:0]    pixel_data,
  input  wire logic                pixel_clock_present,
  input  wire sbl_strap_type       config_strap_select,
  output logic [PIX_W-1:0]         tx_data,
  output logic                     tx_selftest,
  output logic                     wake_request,
  output sbl_src_type              clock_source
);
  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [1:0]        sy_pclk;
    logic [1:0]        sy_lf;
    logic [1:0]        sy_bc;
    logic              cfg_lf;
    logic              cfg_use_reg;
    logic              cfg_osc25;
    logic              active;
    logic              wake;
    sbl_src_type       src;
    logic [PIX_W-1:0]  tx_data;
    logic              awready;
    logic              wready;
    logic              aw_held;
    logic              w_held;
    logic [ADDR_W-1:0] awaddr;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              arready;
    logic              rvalid;
    logic [1:0]        rresp;
    logic [31:0]       rdata;
  } sbl_state_type;

  sbl_state_type    st_reg;
  sbl_state_type    st_next;
  logic             lf_eff;
  logic             bc_eff;
  logic             req_ok;
  logic             do_write;
  logic             clr_bist;
  logic             clr_func;
  logic             enter_pulse;
  logic [CNT_W-1:0] bist_count;
  logic [CNT_W-1:0] func_count;
  logic [15:0]      osc_khz;

  // ----------------------------------------------------------------------
  // crc error counters
  // ----------------------------------------------------------------------
  // self-test counter: counts only in test, cleared on entry
  sbl_err_counter u_bist_cnt (
    .aclk    (aclk),
    .aresetn (aresetn),
    .en      (st_reg.active & bc_link_detect),
    .inc     (bc_crc_error),
    .clr     (clr_bist | enter_pulse),
    .count   (bist_count)
  );

  // functional counter: counts when not in test and link detect is high
  sbl_err_counter u_func_cnt (
    .aclk    (aclk),
    .aresetn (aresetn),
    .en      (~st_reg.active & bc_link_detect),
    .inc     (bc_crc_error),
    .clr     (clr_func),
    .count   (func_count)
  );

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    // two-flop synchronisers for pins
    st_next.sy_pclk = {st_reg.sy_pclk[0], pixel_clock_present};
    st_next.sy_lf = {st_reg.sy_lf[0], config_strap_select.low_freq};
    st_next.sy_bc = {st_reg.sy_bc[0], config_strap_select.backward_compat};

    // low-freq option: strap or register; compatible option: strap only
    lf_eff = st_reg.cfg_use_reg ? st_reg.cfg_lf : st_reg.sy_lf[1];
    bc_eff = st_reg.sy_bc[1];
    req_ok = bc_selftest_req & ~bc_eff;

    // wake while the far end asks for test, unless in compatible mode
    st_next.wake = req_ok;

    // enter or leave test only at a frame boundary
    if (frame_start) begin
      st_next.active = req_ok;
    end
    enter_pulse = st_next.active & ~st_reg.active;

    // zeros replace pixels during test, to encoder at line rate
    st_next.tx_data = st_next.active ? '0 : pixel_data;

    // test clock source
    if (st_reg.sy_pclk[1]) begin
      st_next.src = SRC_PIXEL;
    end else if (lf_eff) begin
      st_next.src = SRC_OSC_12P5;
    end else if (st_reg.cfg_osc25) begin
      st_next.src = SRC_OSC_25;
    end else begin
      st_next.src = SRC_OSC_33;
    end

    // --- write channel ---
    if (s_axi_awvalid && st_reg.awready) begin
      st_next.aw_held = 1'b1;
      st_next.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && st_reg.wready) begin
      st_next.w_held = 1'b1;
      st_next.wdata = s_axi_wdata;
      st_next.wstrb = s_axi_wstrb;
    end
    if (st_reg.bvalid && s_axi_bready) begin
      st_next.bvalid = 1'b0;
    end
    do_write = st_reg.aw_held & st_reg.w_held & ~st_reg.bvalid;
    clr_bist = 1'b0;
    clr_func = 1'b0;
    if (do_write) begin
      st_next.aw_held = 1'b0;
      st_next.w_held = 1'b0;
      st_next.bvalid = 1'b1;
      st_next.bresp = RESP_OKAY;
      case (st_reg.awaddr)
        OFS_CTRL: begin
          if (st_reg.wstrb[0]) begin
            st_next.cfg_lf = st_reg.wdata[CTRL_LF_BIT];
            st_next.cfg_use_reg = st_reg.wdata[CTRL_USE_REG_BIT];
            st_next.cfg_osc25 = st_reg.wdata[CTRL_OSC25_BIT];
          end
        end
        OFS_CLEAR: begin
          clr_bist = st_reg.wstrb[0] & st_reg.wdata[CLR_BIST_BIT];
          clr_func = st_reg.wstrb[0] & st_reg.wdata[CLR_FUNC_BIT];
        end
        OFS_STATUS, OFS_BIST_CRC, OFS_FUNC_CRC: begin
          st_next.bresp = RESP_OKAY; // read-only, write ignored
        end
        default: begin
          st_next.bresp = RESP_SLVERR;
        end
      endcase
    end
    st_next.awready = ~st_next.aw_held & ~st_next.bvalid;
    st_next.wready = ~st_next.w_held & ~st_next.bvalid;

    // --- read channel ---
    case (st_reg.src)
      SRC_OSC_33: osc_khz = OSC_33_KHZ;
      SRC_OSC_25: osc_khz = OSC_25_KHZ;
      SRC_OSC_12P5: osc_khz = OSC_12P5_KHZ;
      default: osc_khz = '0;
    endcase
    if (st_reg.rvalid && s_axi_rready) begin
      st_next.rvalid = 1'b0;
    end
    if (s_axi_arvalid && st_reg.arready) begin
      st_next.rvalid = 1'b1;
      st_next.rresp = RESP_OKAY;
      st_next.rdata = '0;
      case (s_axi_araddr)
        OFS_CTRL: begin
          st_next.rdata[CTRL_LF_BIT] = st_reg.cfg_lf;
          st_next.rdata[CTRL_USE_REG_BIT] = st_reg.cfg_use_reg;
          st_next.rdata[CTRL_OSC25_BIT] = st_reg.cfg_osc25;
        end
        OFS_STATUS: begin
          st_next.rdata[ST_ACTIVE_BIT] = st_reg.active;
          st_next.rdata[ST_LINK_BIT] = bc_link_detect;
          st_next.rdata[ST_PCLK_BIT] = st_reg.sy_pclk[1];
          st_next.rdata[ST_BC_BIT] = bc_eff;
          st_next.rdata[ST_SRC_LSB +: 2] = st_reg.src;
          st_next.rdata[ST_KHZ_LSB +: 16] = osc_khz;
        end
        OFS_BIST_CRC: st_next.rdata[CNT_W-1:0] = bist_count;
        OFS_FUNC_CRC: st_next.rdata[CNT_W-1:0] = func_count;
        OFS_CLEAR: st_next.rdata = '0;
        default: st_next.rresp = RESP_SLVERR;
      endcase
    end
    st_next.arready = ~st_next.rvalid;
  end

  // ----------------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= '0;
      st_reg.cfg_lf <= CTRL_LF_RST;
      st_reg.cfg_use_reg <= CTRL_USE_REG_RST;
      st_reg.cfg_osc25 <= CTRL_OSC25_RST;
      st_reg.src <= SRC_OSC_33;
    end else begin
      st_reg <= st_next;
    end
  end

  // outputs straight from the state register
  assign s_axi_awready = st_reg.awready;
  assign s_axi_wready = st_reg.wready;
  assign s_axi_bvalid = st_reg.bvalid;
  assign s_axi_bresp = st_reg.bresp;
  assign s_axi_arready = st_reg.arready;
  assign s_axi_rvalid = st_reg.rvalid;
  assign s_axi_rresp = st_reg.rresp;
  assign s_axi_rdata = st_reg.rdata;
  assign tx_data = st_reg.tx_data;
  assign tx_selftest = st_reg.active;
  assign wake_request = st_reg.wake;
  assign clock_source = st_reg.src;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence s_enter_req;
    frame_start && req_ok && !st_reg.active;
  endsequence

  sequence s_in_test;
    st_reg.active && tx_data == '0;
  endsequence

  a_test_entry: assert property (s_enter_req |=> s_in_test)
    else $error("self-test not entered at frame start");
  a_zero_pattern: assert property (tx_selftest |-> tx_data == '0)
    else $error("pixel data leaked during self-test");
  a_pixel_resume: assert property (
    !tx_selftest && $past(aresetn) |-> tx_data == $past(pixel_data))
    else $error("pixel data not passed outside self-test");
  a_frame_switch: assert property (
    $changed(tx_selftest) |-> $past(frame_start))
    else $error("mode changed off a frame boundary");
  a_compat_block: assert property (
    bc_eff && !st_reg.active |=> !st_reg.active)
    else $error("self-test entered in compatible mode");
  a_wake_follow: assert property (req_ok |=> wake_request)
    else $error("no wake on self-test request");
  a_osc_low: assert property (
    !st_reg.sy_pclk[1] && lf_eff |=> clock_source == SRC_OSC_12P5)
    else $error("low range oscillator not chosen");
  a_osc_normal: assert property (
    !st_reg.sy_pclk[1] && !lf_eff |=>
    clock_source == ($past(st_reg.cfg_osc25) ? SRC_OSC_25 : SRC_OSC_33))
    else $error("normal range oscillator wrong");
  a_strap_source: assert property (
    !st_reg.cfg_use_reg |-> lf_eff == st_reg.sy_lf[1])
    else $error("strap option not used");
  a_bist_clear: assert property (
    $rose(st_reg.active) |-> bist_count == '0)
    else $error("self-test counter not cleared on entry");
  a_bist_hold: assert property (
    !st_reg.active && !st_next.active && !clr_bist |=>
    $stable(bist_count))
    else $error("self-test counter moved outside test");
  a_func_hold: assert property (
    st_reg.active && !clr_func |=> $stable(func_count))
    else $error("functional counter moved during test");
  a_crc_gate: assert property (
    !bc_link_detect && !clr_func && !st_reg.active |=>
    $stable(func_count))
    else $error("crc counted without link detect");
  a_crc_count: assert property (
    bc_link_detect && bc_crc_error && !st_reg.active && !clr_func &&
    func_count < 8'hFF |=> func_count == $past(func_count) + 8'h01)
    else $error("crc error not counted");
endmodule
`default_nettype wire

// ### verif/sbl_far_end_model.sv
// Purpose : far-end deserializer model on the back channel
// Assumes : one clock shared with the serializer block
// Notes   : frame pulses run free; crc errors come from a task
`timescale 1ns/1ps
`default_nettype none
module sbl_far_end_model #(
  parameter int FRAME_LEN = 12,
  parameter int DATA_W    = 24
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              selftest_enable,
  input  wire logic              link_ok,
  input  wire logic              tx_selftest,
  input  wire logic [DATA_W-1:0] tx_data,
  output logic                   bc_selftest_req,
  output logic                   bc_link_detect,
  output logic                   bc_crc_error,
  output logic                   frame_start,
  output logic                   selftest_result,
  output logic      [DATA_W-1:0] rx_pixel,
  output logic      [7:0]        link_errors,
  output logic                   rx_locked
);
  int   frame_cnt;
  logic chk_q;
  logic err_hit;
  logic pass_q;

  initial bc_crc_error = 1'b0;

  // ---------------------------------------------------------------
  // frame pulses, request and lock over the back channel
  // ---------------------------------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      frame_cnt <= 0;
      frame_start <= 1'b0;
      bc_selftest_req <= 1'b0;
      bc_link_detect <= 1'b0;
    end else begin
      frame_cnt <= (frame_cnt == FRAME_LEN - 1) ? 0 : frame_cnt + 1;
      frame_start <= (frame_cnt == 0);
      bc_selftest_req <= selftest_enable;
      bc_link_detect <= link_ok;
    end
  end

  // ---------------------------------------------------------------
  // zero-stream check, result pin, switching pattern, link status
  // ---------------------------------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      chk_q <= 1'b0;
      err_hit <= 1'b0;
      pass_q <= 1'b0;
      rx_pixel <= '0;
      link_errors <= 8'h00;
      rx_locked <= 1'b0;
    end else begin
      chk_q <= selftest_enable && tx_selftest && link_ok;
      err_hit <= chk_q && tx_selftest && (tx_data != '0);
      if (!chk_q && selftest_enable && tx_selftest && link_ok) begin
        pass_q <= 1'b1;
      end else if (chk_q && tx_selftest && (tx_data != '0)) begin
        pass_q <= 1'b0;
      end
      rx_pixel <= chk_q ? ~rx_pixel : tx_data;
      rx_locked <= link_ok;
      if (rx_locked && !link_ok) begin
        link_errors <= link_errors + 8'h01;
      end
    end
  end

  // while checking, low for the first half of an error cycle, else high; otherwise the held result
  assign selftest_result = chk_q ? ~(err_hit & aclk) : pass_q;

  // one-cycle crc error pulses, two cycles apart
  task automatic send_errors(input int n);
    repeat (n) begin
      @(posedge aclk);
      bc_crc_error <= 1'b1;
      @(posedge aclk);
      bc_crc_error <= 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// ### verif/serial_link_bist_tb.sv
// Purpose : self-checking bench of the serial link self-test block
// Assumes : far-end model makes frames and back-channel traffic
// Notes   : bus tasks wait on each handshake with no bound of their own
`timescale 1ns/1ps
`default_nettype none
module serial_link_bist_tb
  import sbl_pkg::*;
;
  logic             aclk, aresetn;
  logic [7:0]       awaddr, araddr;
  logic [31:0]      wdata, rdata;
  logic [1:0]       bresp, rresp;
  logic             awvalid, awready, wvalid, wready, bvalid, bready;
  logic             arvalid, arready, rvalid, rready;
  logic             req_en, link_ok, fs, req, ld, crc, wake, tx_st, pclk_ok;
  logic [PIX_W-1:0] pix, txd, rx_pix;
  logic             st_res, rx_lock;
  logic [7:0]       lerr;
  sbl_strap_type    strap;
  sbl_src_type      src;
  int               failures, compares;

  sbl_selftest dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .bc_selftest_req(req),
    .bc_link_detect(ld), .bc_crc_error(crc), .frame_start(fs),
    .pixel_data(pix), .pixel_clock_present(pclk_ok),
    .config_strap_select(strap), .tx_data(txd), .tx_selftest(tx_st),
    .wake_request(wake), .clock_source(src));

  sbl_far_end_model far (.aclk(aclk), .aresetn(aresetn),
    .selftest_enable(req_en), .link_ok(link_ok), .bc_selftest_req(req),
    .bc_link_detect(ld), .bc_crc_error(crc), .frame_start(fs),
    .tx_selftest(tx_st), .tx_data(txd), .selftest_result(st_res),
    .rx_pixel(rx_pix), .link_errors(lerr), .rx_locked(rx_lock));

  // ---------------------------------------------------------------
  // clock, checks and bus tasks
  // ---------------------------------------------------------------
  always #50 aclk = ~aclk;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask

  task automatic end_sim();
    if (failures == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er = RESP_OKAY);
    logic       got;
    logic [1:0] r;
    r = 2'h3;
    got = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!got) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        r = bresp;
        got = 1'b1;
      end
    end
    bready <= 1'b0;
    @(posedge aclk);
    chk({30'h0, r}, {30'h0, er});
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    logic got;
    r = 2'h3;
    d = 32'hDEAD_BEEF;
    got = 1'b0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!got) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        r = rresp;
        d = rdata;
        got = 1'b1;
      end
    end
    rready <= 1'b0;
    @(posedge aclk);
  endtask

  // low status bits: active, link detect, pixel clock, compatible
  task automatic bits_chk(input logic [3:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    rd(OFS_STATUS, d, r);
    chk({28'h0, d[3:0]}, {28'h0, exp});
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp,
                        input logic [1:0] er = RESP_OKAY);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk(d, exp);
    chk({30'h0, r}, {30'h0, er});
  endtask

  // status word and port agree on the timing source
  task automatic st_chk(input sbl_src_type s, input logic [15:0] khz);
    logic [31:0] d;
    logic [1:0] r;
    cyc(4);
    rd(OFS_STATUS, d, r);
    chk({16'h0, d[31:16]}, {16'h0, khz});
    chk({30'h0, d[5:4]}, {30'h0, s});
    chk({30'h0, src}, {30'h0, s});
  endtask

  // wait for a mode change; it must follow a frame pulse
  task automatic wait_mode(input logic v);
    int i;
    logic fs_q;
    fs_q = 1'b0;
    for (i = 0; i < 40; i++) begin
      @(posedge aclk);
      if (tx_st === v) break;
      fs_q = fs;
    end
    chk({31'h0, fs_q}, 32'h0000_0001);
    chk({31'h0, tx_st}, {31'h0, v});
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_regs();
    rd_chk(OFS_CTRL, 32'h0000_0000);
    st_chk(SRC_OSC_33, OSC_33_KHZ);
    rd_chk(8'h20, 32'h0000_0000, RESP_SLVERR);
    wr(8'h24, 32'h0000_0007, RESP_SLVERR);
    rd_chk(OFS_CTRL, 32'h0000_0000);
  endtask

  task automatic t_clock();
    wr(OFS_CTRL, 32'h0000_0006);
    st_chk(SRC_OSC_25, OSC_25_KHZ);
    wr(OFS_CTRL, 32'h0000_0007);
    st_chk(SRC_OSC_12P5, OSC_12P5_KHZ);
    wr(OFS_CTRL, 32'h0000_0000);
    strap.low_freq <= 1'b1;
    st_chk(SRC_OSC_12P5, OSC_12P5_KHZ);
    wr(OFS_CTRL, 32'h0000_0002);
    st_chk(SRC_OSC_33, OSC_33_KHZ);
    pclk_ok <= 1'b1;
    st_chk(SRC_PIXEL, 16'h0000);
    pclk_ok <= 1'b0;
    strap.low_freq <= 1'b0;
    wr(OFS_CTRL, 32'h0000_0000);
    st_chk(SRC_OSC_33, OSC_33_KHZ);
  endtask

  task automatic t_selftest();
    logic [PIX_W-1:0] sso_q;
    pix <= 24'hA5_5A3C;
    link_ok <= 1'b1;
    req_en <= 1'b1;
    wait_mode(1'b1);
    chk({31'h0, wake}, 32'h0000_0001);
    pix <= 24'hFF_FFFF;
    cyc(2);
    chk({8'h0, txd}, 32'h0000_0000);
    chk({31'h0, st_res}, 32'h0000_0001);
    sso_q = rx_pix;
    cyc(1);
    chk({8'h0, rx_pix}, {8'h0, ~sso_q});
    bits_chk(4'h3);
    far.send_errors(3);
    cyc(2);
    rd_chk(OFS_BIST_CRC, 32'h0000_0003);
    rd_chk(OFS_FUNC_CRC, 32'h0000_0000);
    link_ok <= 1'b0;
    cyc(3);
    far.send_errors(2);
    cyc(2);
    rd_chk(OFS_BIST_CRC, 32'h0000_0003);
    link_ok <= 1'b1;
    req_en <= 1'b0;
    wait_mode(1'b0);
    cyc(2);
    chk({8'h0, txd}, 32'h00FF_FFFF);
    chk({31'h0, wake}, 32'h0000_0000);
    chk({31'h0, st_res}, 32'h0000_0001);
    far.send_errors(4);
    cyc(2);
    rd_chk(OFS_FUNC_CRC, 32'h0000_0004);
    rd_chk(OFS_BIST_CRC, 32'h0000_0003);
    req_en <= 1'b1;
    wait_mode(1'b1);
    rd_chk(OFS_BIST_CRC, 32'h0000_0000);
    rd_chk(OFS_FUNC_CRC, 32'h0000_0004);
    far.send_errors(2);
    req_en <= 1'b0;
    wait_mode(1'b0);
    rd_chk(OFS_BIST_CRC, 32'h0000_0002);
    wr(OFS_CLEAR, 32'h0000_0001);
    rd_chk(OFS_BIST_CRC, 32'h0000_0000);
    rd_chk(OFS_FUNC_CRC, 32'h0000_0004);
    chk({24'h0, lerr}, 32'h0000_0001);
    chk({31'h0, rx_lock}, 32'h0000_0001);
  endtask

  task automatic t_sat();
    far.send_errors(260);
    cyc(2);
    rd_chk(OFS_FUNC_CRC, 32'h0000_00FF);
    wr(OFS_CLEAR, 32'h0000_0002);
    rd_chk(OFS_FUNC_CRC, 32'h0000_0000);
  endtask

  task automatic t_compat();
    strap.backward_compat <= 1'b1;
    cyc(4);
    req_en <= 1'b1;
    cyc(30);
    chk({31'h0, tx_st}, 32'h0000_0000);
    chk({31'h0, wake}, 32'h0000_0000);
    bits_chk(4'hA);
    req_en <= 1'b0;
    strap.backward_compat <= 1'b0;
    cyc(4);
  endtask

  // ---------------------------------------------------------------
  // main sequence and watchdog
  // ---------------------------------------------------------------
  initial begin
    aclk = 1'b0;
    aresetn = 1'b0;
    {awaddr, araddr, wdata} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    {req_en, link_ok, pclk_ok} = '0;
    pix = 24'h00_0000;
    strap = '0;
    failures = 0;
    compares = 0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    cyc(2);
    t_regs();
    t_clock();
    t_selftest();
    t_sat();
    t_compat();
    end_sim();
  end

  initial begin
    #3_000_000;
    failures++;
    end_sim();
  end
endmodule
`default_nettype wire
